// ==== design/hbridge_input_decoder.sv ====
// H-bridge input decoder: deglitch, decode, sleep control, sense gating.
// Assumes both control inputs are synchronous to CORE_CLK_I and that
// the analog side reports drain-to-source current per low-side leg.
//
// Notes on behaviour
// - both inputs low turns all four transistors off, outputs float.
// - coast held about one millisecond puts the bridge to sleep, outputs float.
// - A low, B high drives output A low and output B high.
// - A high, B low drives output A high and output B low.
// - both inputs high turns both low sides on, braking the motor.
// - inputs may be static levels or modulated; both are served alike.
// - a leg passes through both-off dead time between high and low.
// - each input is deglitched so short pulses change nothing.
// - latency from input edge includes deglitch and logic delay.
// - only drain-to-source current in a conducting low side is reported.
// - in brake only the one conducting low side is reported.
// - coast gives no sense indication at all.
// - sense becomes valid only after the sense delay from low-side enable.
// - drive-brake alternation keeps sense valid with no new delay.
// - a command turning low sides off drops sense at once.
// - sense delay is 1.1 us.
// - sleep entry lies between 0.8 and 1.5 ms of coast.
// - wake completes within 250 us of an input going high; the code waits a full 250 us wake count after the deglitch window.
`timescale 1ns/100ps
`include "hbridge_cfg.svh"

module hbridge_input_decoder #(
  parameter int DEGLITCH_CYC = `HB_DEGLITCH_CYC,
  parameter int DEAD_CYC     = `HB_DEAD_CYC,
  parameter int SENSE_CYC    = `HB_SENSE_DELAY_CYC,
  parameter int SLEEP_CYC    = `HB_SLEEP_CYC,
  parameter int WAKE_CYC     = `HB_WAKE_CYC
) (
  // Clock and reset
  input  wire logic CORE_CLK_I,
  input  wire logic RST_I,
  // Control inputs from the host
  input  wire logic CONTROL_INPUT_A_I,
  input  wire logic CONTROL_INPUT_B_I,
  // Drain-to-source current present in each low-side leg
  input  wire logic LOW_SIDE_LEG_CURRENT_A_I,
  input  wire logic LOW_SIDE_LEG_CURRENT_B_I,
  // Gate enables of the bridge
  output logic      BRIDGE_OUTPUT_A_HIGH_O,
  output logic      BRIDGE_OUTPUT_A_LOW_O,
  output logic      BRIDGE_OUTPUT_B_HIGH_O,
  output logic      BRIDGE_OUTPUT_B_LOW_O,
  // Current sense gating and power state
  output logic      CURRENT_SENSE_VALID_O,
  output logic      CURRENT_SENSE_LEG_A_O,
  output logic      CURRENT_SENSE_LEG_B_O,
  output logic      SLEEP_O
);
  import hbridge_pkg::*;

  localparam int DGW = $clog2(DEGLITCH_CYC + 1);
  localparam int SNW = $clog2(SENSE_CYC + 1);
  localparam int PMX = (SLEEP_CYC > WAKE_CYC) ? SLEEP_CYC : WAKE_CYC;
  localparam int PWW = $clog2(PMX + 1);

  generate
    if (DEGLITCH_CYC < 2 || SENSE_CYC < 2 || SLEEP_CYC < 2 || WAKE_CYC < 1) begin : g_bad_param
      $error("hbridge_input_decoder: interval parameter too small");
    end
  endgenerate

  logic [1:0]           raw;
  logic [1:0]           filt_reg;
  logic [DGW-1:0]       deg_cnt_reg [2];
  bridge_cmd_t          cmd;
  pwr_state_t           pwr_reg;
  pwr_state_t           pwr_next;
  logic [PWW-1:0]       pwr_cnt_reg;
  logic                 active;
  leg_state_t           want [2];
  logic [1:0]           hs_on;
  logic [1:0]           ls_on;
  logic [1:0]           ls_cmd;
  logic [1:0]           ls_prev_reg;
  logic                 sense_restart;
  logic                 sense_ready;
  logic [SNW-1:0]       sense_cnt_reg;

  assign raw = {CONTROL_INPUT_B_I, CONTROL_INPUT_A_I};

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  // ----------------------------------------------------------------
  // Input deglitch, one filter per input
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_deglitch
    // level must hold the whole window; restart on change
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
        filt_reg[i]    <= 1'b0;
        deg_cnt_reg[i] <= '0;
      end else if (raw[i] == filt_reg[i]) begin
        deg_cnt_reg[i] <= '0;
      end else if (deg_cnt_reg[i] == DGW'(DEGLITCH_CYC - 1)) begin
        filt_reg[i]    <= raw[i];
        deg_cnt_reg[i] <= '0;
      end else begin
        deg_cnt_reg[i] <= deg_cnt_reg[i] + 1'b1;
      end
    end

    chk_deglitch_hold: assert property (
      $changed(filt_reg[i]) |-> ($past(raw[i], 1) == filt_reg[i])
                             && ($past(raw[i], 2) == filt_reg[i]))
      else $error("filtered input moved without a held level");
  end

  assign cmd = bridge_cmd_t'({filt_reg[0], filt_reg[1]});

  // ----------------------------------------------------------------
  // Power state: sleep, wake, active
  // ----------------------------------------------------------------
  // coast count to sleep, input high counts to wake
  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      PWR_SLEEP: begin
        if (filt_reg != 2'h0) begin
          pwr_next = PWR_WAKING;
        end
      end
      PWR_WAKING: begin
        if (filt_reg == 2'h0) begin
          pwr_next = PWR_SLEEP;
        end else if (pwr_cnt_reg == PWW'(WAKE_CYC - 1)) begin
          pwr_next = PWR_ACTIVE;
        end
      end
      PWR_ACTIVE: begin
        if (filt_reg == 2'h0 && pwr_cnt_reg == PWW'(SLEEP_CYC - 1)) begin
          pwr_next = PWR_SLEEP;
        end
      end
      default: pwr_next = PWR_SLEEP;
    endcase
  end

  // Power-up with inputs low goes straight to sleep
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pwr_reg <= PWR_SLEEP;
      SLEEP_O <= 1'b1;
    end else begin
      pwr_reg <= pwr_next;
      SLEEP_O <= (pwr_next == PWR_SLEEP);
    end
  end

  // one counter, cleared whenever its cause changes
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pwr_cnt_reg <= '0;
    end else if (pwr_next != pwr_reg) begin
      pwr_cnt_reg <= '0;
    end else if (pwr_reg == PWR_WAKING
              || (pwr_reg == PWR_ACTIVE && filt_reg == 2'h0)) begin
      pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
    end else begin
      pwr_cnt_reg <= '0;
    end
  end

  assign active = (pwr_reg == PWR_ACTIVE);

  chk_sleep_entry: assert property (
    (active && cmd == CMD_COAST && pwr_cnt_reg == PWW'(SLEEP_CYC - 1))
      |=> (pwr_reg == PWR_SLEEP) && SLEEP_O)
    else $error("sleep not entered at end of coast interval");

  chk_wake_bound: assert property (
    (pwr_reg == PWR_WAKING) |-> (pwr_cnt_reg < PWW'(WAKE_CYC)))
    else $error("wake interval overran");

  // ----------------------------------------------------------------
  // Decode and half-bridge legs
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_leg
    // own input alone drives high, other input drives low
    always_comb begin
      if (!active) begin
        want[i] = LEG_OFF;
      end else if (filt_reg[1 - i]) begin
        want[i] = LEG_LOW;
      end else if (filt_reg[i]) begin
        want[i] = LEG_HIGH;
      end else begin
        want[i] = LEG_OFF;
      end
    end

    hbridge_leg #(
      .DEAD_CYC (DEAD_CYC)
    ) u_leg (
      .clk_i   (CORE_CLK_I),
      .rst_i   (RST_I),
      .want_i  (want[i]),
      .hs_on_o (hs_on[i]),
      .ls_on_o (ls_on[i])
    );
    assign ls_cmd[i] = (want[i] == LEG_LOW);
  end

  assign BRIDGE_OUTPUT_A_HIGH_O = hs_on[0];
  assign BRIDGE_OUTPUT_A_LOW_O  = ls_on[0];
  assign BRIDGE_OUTPUT_B_HIGH_O = hs_on[1];
  assign BRIDGE_OUTPUT_B_LOW_O  = ls_on[1];

  sequence s_held(bridge_cmd_t c);
    (active && cmd == c) [*8];
  endsequence

  chk_coast_all_off: assert property (
    (!active || cmd == CMD_COAST) |=> (hs_on == 2'h0) && (ls_on == 2'h0))
    else $error("transistor on during coast or sleep");

  chk_reverse_drive: assert property (
    s_held(CMD_REVERSE) |-> ls_on[0] && hs_on[1] && !hs_on[0] && !ls_on[1])
    else $error("reverse drive not applied");

  chk_forward_drive: assert property (
    s_held(CMD_FORWARD) |-> hs_on[0] && ls_on[1] && !ls_on[0] && !hs_on[1])
    else $error("forward drive not applied");

  chk_brake_drive: assert property (
    s_held(CMD_BRAKE) |-> (ls_on == 2'h3) && (hs_on == 2'h0))
    else $error("brake not applied");

  // ----------------------------------------------------------------
  // Current sense gating
  // ----------------------------------------------------------------
  // Sense follows the command, not the slewing gates, so it drops at once
  // restart only when no sensing low side stays on across the change
  assign sense_restart = ((ls_cmd & ls_prev_reg) == 2'h0);
  // ready only with a low side commanded and delay spent
  assign sense_ready   = (ls_cmd != 2'h0) && !sense_restart
                      && (sense_cnt_reg >= SNW'(SENSE_CYC - 1));

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ls_prev_reg   <= 2'h0;
      sense_cnt_reg <= '0;
    end else begin
      ls_prev_reg <= ls_cmd;
      if (sense_restart) begin
        sense_cnt_reg <= '0;
      end else if (sense_cnt_reg < SNW'(SENSE_CYC)) begin
        sense_cnt_reg <= sense_cnt_reg + 1'b1;
      end
    end
  end

  // a leg counts only while on and conducting drain to source
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CURRENT_SENSE_VALID_O <= 1'b0;
      CURRENT_SENSE_LEG_A_O <= 1'b0;
      CURRENT_SENSE_LEG_B_O <= 1'b0;
    end else begin
      CURRENT_SENSE_VALID_O <= sense_ready;
      CURRENT_SENSE_LEG_A_O <= sense_ready && ls_cmd[0] && LOW_SIDE_LEG_CURRENT_A_I;
      CURRENT_SENSE_LEG_B_O <= sense_ready && ls_cmd[1] && LOW_SIDE_LEG_CURRENT_B_I;
    end
  end

  chk_sense_drop: assert property (
    (ls_cmd == 2'h0) |=> !CURRENT_SENSE_VALID_O && !CURRENT_SENSE_LEG_A_O
                         && !CURRENT_SENSE_LEG_B_O)
    else $error("sense still valid after low sides commanded off");

  chk_sense_delay: assert property (
    $rose(CURRENT_SENSE_VALID_O) |-> ($past(ls_cmd, SENSE_CYC) != 2'h0))
    else $error("sense valid before the sense delay");

  chk_sense_keep: assert property (
    (CURRENT_SENSE_VALID_O && ((ls_cmd & ls_prev_reg) != 2'h0)) |=> CURRENT_SENSE_VALID_O)
    else $error("sense dropped while a low side stayed on");

  chk_sense_leg: assert property (
    CURRENT_SENSE_LEG_A_O |-> $past(ls_cmd[0]) && $past(LOW_SIDE_LEG_CURRENT_A_I))
    else $error("leg A reported without drain-to-source current");

endmodule : hbridge_input_decoder

// ==== common/hbridge_cfg.svh ====
// Timing constants of the H-bridge input decoder, all as macros.
// Assumes the core clock runs at the rate given by HB_CLK_PERIOD_NS.
`ifndef HBRIDGE_CFG_SVH
`define HBRIDGE_CFG_SVH

`define HB_CLK_PERIOD_NS   40

// Dead time between opposite transistors of one leg (least time, rounds up)
`define HB_DEAD_TIME_NS    200
`define HB_DEAD_CYC        ((`HB_DEAD_TIME_NS + `HB_CLK_PERIOD_NS - 1) / `HB_CLK_PERIOD_NS)

// Input deglitch window (least time, rounds up)
`define HB_DEGLITCH_NS     400
`define HB_DEGLITCH_CYC    ((`HB_DEGLITCH_NS + `HB_CLK_PERIOD_NS - 1) / `HB_CLK_PERIOD_NS)

// Sense ready delay after a low-side enable (least time, rounds up)
`define HB_SENSE_DELAY_NS  1100
`define HB_SENSE_DELAY_CYC ((`HB_SENSE_DELAY_NS + `HB_CLK_PERIOD_NS - 1) / `HB_CLK_PERIOD_NS)

// Coast time before sleep, nominal within the 0.8 ms to 1.5 ms window
`define HB_SLEEP_NS        1000000
`define HB_SLEEP_CYC       (`HB_SLEEP_NS / `HB_CLK_PERIOD_NS)

// Wake time, longest allowed (rounds down)
`define HB_WAKE_NS         250000
`define HB_WAKE_CYC        (`HB_WAKE_NS / `HB_CLK_PERIOD_NS)

`endif

// ==== common/hbridge_pkg.sv ====
// Types shared by the H-bridge input decoder and its half-bridge legs.
// Assumes the timing macros come from hbridge_cfg.svh.
package hbridge_pkg;

  // Decoded input pair, input A is the upper bit
  typedef enum logic [1:0] {
    CMD_COAST   = 2'b00,
    CMD_REVERSE = 2'b01,
    CMD_FORWARD = 2'b10,
    CMD_BRAKE   = 2'b11
  } bridge_cmd_t;

  // State of one half-bridge leg
  typedef enum logic [1:0] {
    LEG_OFF  = 2'b00,
    LEG_HIGH = 2'b01,
    LEG_LOW  = 2'b10
  } leg_state_t;

  // Power state of the bridge
  typedef enum logic [1:0] {
    PWR_SLEEP  = 2'b00,
    PWR_WAKING = 2'b01,
    PWR_ACTIVE = 2'b10
  } pwr_state_t;

endpackage : hbridge_pkg

// ==== design/hbridge_leg.sv ====
// One half-bridge leg: gate enables for its high and low transistor.
// Assumes want_i is already deglitched; inserts the dead time itself.
`timescale 1ns/100ps
`include "hbridge_cfg.svh"

module hbridge_leg #(
  parameter int DEAD_CYC = `HB_DEAD_CYC
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Requested leg state
  input  wire hbridge_pkg::leg_state_t want_i,
  // Gate enables
  output logic                        hs_on_o,
  output logic                        ls_on_o
);
  import hbridge_pkg::*;

  localparam int CW = $clog2(DEAD_CYC + 1);

  generate
    if (DEAD_CYC < 1) begin : g_bad_dead
      $error("hbridge_leg: DEAD_CYC must be at least 1");
    end
  endgenerate

  leg_state_t      cur_reg;
  leg_state_t      cur_next;
  logic [CW-1:0]   dead_cnt_reg;

  // ----------------------------------------------------------------
  // Leg state
  // ----------------------------------------------------------------
  // off interval between drives
  always_comb begin
    cur_next = cur_reg;
    case (cur_reg)
      LEG_OFF: begin
        if (want_i != LEG_OFF && dead_cnt_reg == '0) begin
          cur_next = want_i;
        end
      end
      LEG_HIGH, LEG_LOW: begin
        if (want_i != cur_reg) begin
          cur_next = LEG_OFF;
        end
      end
      default: cur_next = LEG_OFF;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_reg <= LEG_OFF;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // dead counter restarts on leaving a drive
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dead_cnt_reg <= '0;
    end else if (cur_reg != LEG_OFF && cur_next == LEG_OFF) begin
      dead_cnt_reg <= CW'(DEAD_CYC);
    end else if (dead_cnt_reg != '0) begin
      dead_cnt_reg <= dead_cnt_reg - 1'b1;
    end
  end

  // Gate enables straight from flip-flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hs_on_o <= 1'b0;
      ls_on_o <= 1'b0;
    end else begin
      hs_on_o <= (cur_next == LEG_HIGH);
      ls_on_o <= (cur_next == LEG_LOW);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_no_shoot_through: assert property (
    @(posedge clk_i) disable iff (rst_i) !(hs_on_o && ls_on_o))
    else $error("both transistors of a leg on");

  chk_dead_after_high: assert property (
    @(posedge clk_i) disable iff (rst_i) $fell(hs_on_o) |-> !ls_on_o [*5])
    else $error("low side on inside dead time");

  chk_dead_after_low: assert property (
    @(posedge clk_i) disable iff (rst_i) $fell(ls_on_o) |-> !hs_on_o [*5])
    else $error("high side on inside dead time");

endmodule : hbridge_leg

// ==== test/host_pwm_model.sv ====
// Host controller model: drives the two control pins of the bridge.
// Assumes the bench sets the command and modulation at clock edges.
`timescale 1ns/100ps

module host_pwm_model (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Requested command and modulation
  input  wire hbridge_pkg::bridge_cmd_t cmd_i,
  input  wire logic                     pwm_en_i,
  input  wire logic [7:0]               half_i,
  // Control pins toward the bridge
  output logic                          ctl_a_o,
  output logic                          ctl_b_o
);
  import hbridge_pkg::*;

  logic [7:0] cnt_reg;
  logic       brake_reg;

  // ----------------------------------------
  // Modulation phase
  // ----------------------------------------
  // drive and brake alternation
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg   <= 8'h00;
      brake_reg <= 1'b0;
    end else if (!pwm_en_i) begin
      cnt_reg   <= 8'h00;
      brake_reg <= 1'b0;
    end else if (cnt_reg == half_i - 8'h01) begin
      cnt_reg   <= 8'h00;
      brake_reg <= ~brake_reg;
    end else begin
      cnt_reg   <= cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  // static or modulated levels
  // modulation replaces the command with brake (both pins high) every other phase
  assign {ctl_a_o, ctl_b_o} = brake_reg ? 2'b11 : cmd_i;

endmodule : host_pwm_model

// ==== test/test_hbridge_input_decoder.sv ====
// Self-checking bench of the H-bridge input decoder.
// Assumes the package is compiled first; sleep and wake counts are shortened.
`timescale 1ns/100ps

module test_hbridge_input_decoder;
  import hbridge_pkg::*;

  localparam int DEGLITCH_CYC = 10;
  localparam int DEAD_CYC     = 5;
  localparam int SENSE_CYC    = 28;
  localparam int SLEEP_CYC    = 40;
  localparam int WAKE_CYC     = 20;

  logic        clk;
  logic        rst;
  bridge_cmd_t cmd_r;
  logic        pwm_en;
  logic [7:0]  half;
  logic        ctl_a;
  logic        ctl_b;
  logic        cur_a;
  logic        cur_b;
  logic        ah, al, bh, bl;
  logic        sv, sla, slb, slp;
  logic [3:0]  gates;
  int          fail_count;
  int          n_compared;
  int          n, m, bad, drop;

  assign gates = {ah, al, bh, bl};

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  host_pwm_model host_pwm_model_inst (
    .clk_i(clk), .rst_i(rst), .cmd_i(cmd_r), .pwm_en_i(pwm_en), .half_i(half),
    .ctl_a_o(ctl_a), .ctl_b_o(ctl_b));

  hbridge_input_decoder #(
    .DEGLITCH_CYC(DEGLITCH_CYC), .DEAD_CYC(DEAD_CYC), .SENSE_CYC(SENSE_CYC),
    .SLEEP_CYC(SLEEP_CYC), .WAKE_CYC(WAKE_CYC)
  ) hbridge_input_decoder_inst (
    .CORE_CLK_I(clk), .RST_I(rst), .CONTROL_INPUT_A_I(ctl_a), .CONTROL_INPUT_B_I(ctl_b),
    .LOW_SIDE_LEG_CURRENT_A_I(cur_a), .LOW_SIDE_LEG_CURRENT_B_I(cur_b),
    .BRIDGE_OUTPUT_A_HIGH_O(ah), .BRIDGE_OUTPUT_A_LOW_O(al),
    .BRIDGE_OUTPUT_B_HIGH_O(bh), .BRIDGE_OUTPUT_B_LOW_O(bl),
    .CURRENT_SENSE_VALID_O(sv), .CURRENT_SENSE_LEG_A_O(sla),
    .CURRENT_SENSE_LEG_B_O(slb), .SLEEP_O(slp));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic drive(input bridge_cmd_t c);
    @(posedge clk);
    cmd_r <= c;
  endtask : drive

  task automatic chk_bit(input string name, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", name, e, g);
    end
  endtask : chk_bit

  task automatic chk_vec(input string name, input logic [3:0] e, input logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", name, e, g);
    end
  endtask : chk_vec

  task automatic chk_cnt(input string name, input int e, input int g);
    n_compared++;
    if (g != e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", name, e, g);
    end
  endtask : chk_cnt

  // Counts edges until the gate pattern shows, bounded by lim
  task automatic wait_gates(input logic [3:0] e, input int lim, output int k);
    k = 0;
    do begin
      step();
      k++;
    end while (gates !== e && k < lim);
  endtask : wait_gates

  task automatic results();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_wake();
    step();
    chk_bit("sleep_after_reset", 1'b1, slp);
    chk_vec("gates_after_reset", 4'b0000, gates);
    drive(CMD_FORWARD);
    n = 0;
    do begin step(); n++; end while (slp !== 1'b0 && n < 40);
    chk_bit("sleep_exit", 1'b1, n <= DEGLITCH_CYC + 2);
    wait_gates(4'b1001, WAKE_CYC + 10, n);
    chk_bit("wake_time", 1'b1, n <= WAKE_CYC + 2);
    chk_vec("forward_gates", 4'b1001, gates);
  endtask : t_reset_wake

  // Every non-coast command entered from coast, so no leg reverses
  task automatic t_latency();
    bridge_cmd_t cs [6] = '{CMD_COAST, CMD_REVERSE, CMD_COAST, CMD_BRAKE, CMD_COAST, CMD_FORWARD};
    logic [3:0]  gs [6] = '{4'b0000, 4'b0110, 4'b0000, 4'b0101, 4'b0000, 4'b1001};
    for (int i = 0; i < 6; i++) begin
      drive(cs[i]);
      wait_gates(gs[i], 30, n);
      chk_vec("command_gates", gs[i], gates);
      chk_cnt("input_latency", DEGLITCH_CYC + 1, n);
    end
  endtask : t_latency

  task automatic t_dead_time();
    drive(CMD_REVERSE);
    n = 0;
    do begin step(); n++; end while (ah !== 1'b0 && n < 30);
    chk_cnt("high_drop", DEGLITCH_CYC + 1, n);
    m = 0;
    while (ah === 1'b0 && al === 1'b0 && m < 20) begin m++; step(); end
    chk_cnt("dead_cycles", DEAD_CYC + 1, m);
    wait_gates(4'b0110, 5, n);
    chk_vec("reverse_gates", 4'b0110, gates);
  endtask : t_dead_time

  task automatic t_glitch();
    bad = 0;
    drive(CMD_BRAKE);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (i == DEGLITCH_CYC - 2)
        cmd_r <= CMD_REVERSE;
      #1;
      if (gates !== 4'b0110)
        bad++;
    end
    chk_cnt("glitch_changes", 0, bad);
  endtask : t_glitch

  task automatic t_sense();
    drive(CMD_COAST);
    wait_gates(4'b0000, 30, n);
    chk_cnt("coast_latency", DEGLITCH_CYC + 1, n);
    bad = 0;
    repeat (25) begin step(); if (sv !== 1'b0) bad++; end
    chk_cnt("coast_valid", 0, bad);
    drive(CMD_FORWARD);
    wait_gates(4'b1001, 30, n);
    n = 0;
    while (sv !== 1'b1 && n < 60) begin step(); n++; end
    chk_bit("sense_delay", 1'b1, n >= SENSE_CYC && n <= SENSE_CYC + 1);
    step();
    chk_bit("leg_b_sense", 1'b1, slb);
    chk_bit("leg_a_sense", 1'b0, sla);
    // Current on a leg whose low side is off must not be reported
    @(posedge clk);
    cur_a <= 1'b1;
    step();
    step();
    chk_bit("leg_a_idle_current", 1'b0, sla);
    @(posedge clk);
    cur_a  <= 1'b0;
    pwm_en <= 1'b1;
    bad = 0;
    m = 0;
    repeat (200) begin
      step();
      if (sv !== 1'b1 || slb !== 1'b1) bad++;
      if (sla !== 1'b0) m++;
    end
    chk_cnt("pwm_valid_drops", 0, bad);
    chk_cnt("brake_leg_a", 0, m);
    @(posedge clk);
    pwm_en <= 1'b0;
    cmd_r  <= CMD_COAST;
    n = 0;
    drop = -1;
    do begin
      step();
      n++;
      if (sv !== 1'b1 && drop < 0) drop = n;
    end while (gates !== 4'b0000 && n < 40);
    chk_bit("sense_off", 1'b1, drop >= 0 && drop <= n);
  endtask : t_sense

  // Continues from coast with gates just released
  task automatic t_sleep();
    n = 0;
    while (slp !== 1'b1 && n < 200) begin step(); n++; end
    chk_bit("sleep_entry", 1'b1, n >= SLEEP_CYC * 4 / 5 && n <= SLEEP_CYC * 3 / 2);
    chk_vec("sleep_gates", 4'b0000, gates);
    chk_bit("sleep_valid", 1'b0, sv);
    drive(CMD_REVERSE);
    wait_gates(4'b0110, 100, n);
    chk_bit("rewake_time", 1'b1, n > WAKE_CYC && n <= DEGLITCH_CYC + WAKE_CYC + 2);
  endtask : t_sleep

  // ----------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    rst        = 1'b1;
    cmd_r      = CMD_COAST;
    pwm_en     = 1'b0;
    half       = 8'h0F;
    cur_a      = 1'b0;
    cur_b      = 1'b1;
    fail_count = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset_wake();
    t_latency();
    t_dead_time();
    t_glitch();
    t_sense();
    t_sleep();
    results();
  end

  // Run needs under a thousand cycles; five thousand means a hang
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    results();
  end

endmodule : test_hbridge_input_decoder
